/* File: rtl/mdfs_top.sv */
// Purpose: Fault latching, bridge disable and status flags of a motor driver.
// Assumes: Analog comparators and the switch pin arrive asynchronously.
// Notes:   Standby pin low acts as the block reset together with sys_rst_in.
`timescale 1ns/100ps

module mdfs_top
  import mdfs_pkg::*;
#(
  parameter int ADC_W = 5
) (
  input  wire logic              sys_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              standby_reset_pin_n_in,
  input  wire mdfs_sense_t       sense_in,
  input  wire logic              pwm_period_in,
  input  wire logic [ADC_W-1:0]  adc_sample_in,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   bridges_off_out,
  output logic                   immediate_stop_out,
  output logic                   motion_accept_out,
  output logic                   alarm_n_out,
  output logic                   alarm_n_oe_out
);

  //--------------------------------------------------------------------
  // Reset and input synchronisers
  //--------------------------------------------------------------------
  logic        stby_s1;
  logic        stby_s2;
  logic        rst;
  mdfs_sense_t sense_s1;
  mdfs_sense_t sense_s2;
  logic        pwm_s1;
  logic        pwm_s2;
  logic        pwm_d;

  // Standby pin is synchronised; the whole block resets while it is low.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stby_s1 <= 1'b0;
      stby_s2 <= 1'b0;
    end else begin
      stby_s1 <= standby_reset_pin_n_in;
      stby_s2 <= stby_s1;
    end
  end

  assign rst = sys_rst_in | ~stby_s2; // [RULE_13]

  // Two flip-flops on every analog and pin input.
  always_ff @(posedge sys_clk_in or posedge rst) begin
    if (rst) begin
      sense_s1 <= '0;
      sense_s2 <= '0;
      pwm_s1   <= 1'b0;
      pwm_s2   <= 1'b0;
      pwm_d    <= 1'b0;
    end else begin
      sense_s1 <= sense_in;
      sense_s2 <= sense_s1;
      pwm_s1   <= pwm_period_in;
      pwm_s2   <= pwm_s1;
      pwm_d    <= pwm_s2;
    end
  end

  //--------------------------------------------------------------------
  // Register bus
  //--------------------------------------------------------------------
  logic [1:0]       cfg;
  logic [7:0]       alarm_en;
  logic [3:0]       overcurrent_threshold;
  logic [ADC_W-1:0] adc_result;
  logic [ADC_W-1:0] adc_s1;
  logic [ADC_W-1:0] adc_s2;
  mdfs_status_t     st;
  logic             aw_hold;
  logic             w_hold;
  logic [7:0]       aw_addr;
  logic [31:0]      w_data;
  logic             w_strb0;
  logic             wr_go;
  logic             read_and_clear_status_cmd;
  logic             motion_cmd;
  logic             status_rd;

  // Writes fire when both address and data have been taken.
  assign wr_go = aw_hold & w_hold & ~s_axi_bvalid;

  // A status-register read counts as a status-read command too.
  assign status_rd = s_axi_arvalid & s_axi_arready &
                     (s_axi_araddr[7:0] == MDFS_STATUS_OFF);

  // Address and data channels are taken independently; the strobe is
  // kept with the data because the master may change it once taken.
  always_ff @(posedge sys_clk_in or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb0       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr[7:0];
      end else if (wr_go) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb0      <= s_axi_wstrb[0];
      end else if (wr_go) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign aw_hold = ~s_axi_awready;
  assign w_hold  = ~s_axi_wready;

  // Configuration registers and the one-cycle command strobes.
  always_ff @(posedge sys_clk_in or posedge rst) begin
    if (rst) begin
      cfg                       <= MDFS_CFG_RST;
      alarm_en                  <= MDFS_ALARM_RST;
      overcurrent_threshold     <= MDFS_OCTH_RST;
      read_and_clear_status_cmd <= 1'b0;
      motion_cmd                <= 1'b0;
      s_axi_bvalid              <= 1'b0;
      s_axi_bresp               <= MDFS_RESP_OKAY;
    end else begin
      read_and_clear_status_cmd <= status_rd; // [RULE_23]
      motion_cmd                <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= MDFS_RESP_OKAY;
        unique case (aw_addr)
          MDFS_CFG_OFF: begin
            if (w_strb0) cfg <= w_data[1:0];
          end
          MDFS_ALARM_OFF: begin
            if (w_strb0) alarm_en <= w_data[7:0];
          end
          MDFS_OCTH_OFF: begin
            if (w_strb0) overcurrent_threshold <= w_data[3:0]; // [RULE_02]
          end
          MDFS_CMD_OFF: begin
            if (w_strb0) begin
              read_and_clear_status_cmd <= w_data[MDFS_CMD_READ_BIT] |
                                           status_rd; // [RULE_23]
              motion_cmd <= w_data[MDFS_CMD_MOTION_BIT];
            end
          end
          MDFS_STATUS_OFF, MDFS_ADC_OFF: ;
          default: begin
            s_axi_bresp <= MDFS_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Read data mux; unmapped addresses answer SLVERR with zero data.
  always_ff @(posedge sys_clk_in or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= MDFS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= MDFS_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      unique case (s_axi_araddr[7:0])
        MDFS_CFG_OFF:    s_axi_rdata[1:0] <= cfg;
        MDFS_STATUS_OFF: s_axi_rdata[6:0] <= st;
        MDFS_ADC_OFF:    s_axi_rdata[ADC_W-1:0] <= adc_result;
        MDFS_ALARM_OFF:  s_axi_rdata[7:0] <= alarm_en;
        MDFS_CMD_OFF:    ;
        MDFS_OCTH_OFF:   s_axi_rdata[3:0] <= overcurrent_threshold;
        default:         s_axi_rresp <= MDFS_RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  //--------------------------------------------------------------------
  // Fault flags
  //--------------------------------------------------------------------
  logic thermal_sd_active;
  logic uv_present;
  logic oc_off;
  logic sw_d;
  logic sw_fall;
  logic motion_ok;

  assign sw_fall = sense_s2.switch_closed & ~sw_d;

  // Active-low flags latch on the condition; a read releases all but thermal
  // shutdown, and only when the condition has gone, so a set always beats the clear.
  always_ff @(posedge sys_clk_in or posedge rst) begin
    if (rst) begin
      st.overcurrent_flag      <= 1'b1;
      st.undervoltage_flag     <= 1'b0; // [RULE_08]
      st.thermal_warning_flag  <= 1'b1;
      st.thermal_shutdown_flag <= 1'b1;
      st.switch_event_flag     <= 1'b0;
      st.switch_level_flag     <= 1'b0;
      sw_d                     <= 1'b0;
      uv_present               <= 1'b0;
      thermal_sd_active        <= 1'b0;
      st.bridges_high_impedance_flag <= 1'b1; // [RULE_16]
    end else begin
      if (sense_s2.overcurrent) begin
        st.overcurrent_flag <= 1'b0; // [RULE_01] [RULE_03]
      end else if (read_and_clear_status_cmd) begin
        st.overcurrent_flag <= 1'b1; // [RULE_01]
      end
      if (sense_s2.supply_below_off) begin
        uv_present <= 1'b1;
      end else if (sense_s2.supply_above_on) begin
        uv_present <= 1'b0;
      end
      if (sense_s2.supply_below_off) begin
        st.undervoltage_flag <= 1'b0; // [RULE_06]
      end else if (read_and_clear_status_cmd && !uv_present &&
                   sense_s2.supply_above_on) begin
        st.undervoltage_flag <= 1'b1; // [RULE_06]
      end
      if (sense_s2.temp_over_warning) begin
        st.thermal_warning_flag <= 1'b0; // [RULE_09]
      end else if (read_and_clear_status_cmd) begin
        st.thermal_warning_flag <= 1'b1; // [RULE_09]
      end
      if (sense_s2.temp_over_shutdown) begin
        thermal_sd_active <= 1'b1; // [RULE_10]
      end else if (!sense_s2.temp_over_warning) begin
        thermal_sd_active <= 1'b0; // [RULE_11]
      end
      st.thermal_shutdown_flag <= ~(thermal_sd_active |
                                    sense_s2.temp_over_shutdown); // [RULE_10]
      if (sense_s2.temp_over_shutdown ||
          (sense_s2.overcurrent && cfg[MDFS_CFG_OCSD_BIT])) begin
        st.bridges_high_impedance_flag <= 1'b1; // [RULE_10]
      end else if (motion_ok) begin
        st.bridges_high_impedance_flag <= 1'b0; // [RULE_12] [RULE_16]
      end
      st.switch_level_flag <= sense_s2.switch_closed; // [RULE_18]
      sw_d                 <= sense_s2.switch_closed;
      if (sw_fall) begin
        st.switch_event_flag <= 1'b1; // [RULE_19]
      end else if (read_and_clear_status_cmd) begin
        st.switch_event_flag <= 1'b0; // [RULE_19]
      end
    end
  end

  //--------------------------------------------------------------------
  // Bridge control and motion gating
  //--------------------------------------------------------------------
  // Motion refused while undervoltage, thermal or overcurrent lockout.
  assign motion_ok = motion_cmd & ~uv_present & ~thermal_sd_active &
                     ~oc_off & ~sense_s2.temp_over_shutdown; // [RULE_07]

  // Overcurrent lockout, bridge drive and the one-cycle pulses.
  always_ff @(posedge sys_clk_in or posedge rst) begin
    if (rst) begin
      oc_off                         <= 1'b0;
      bridges_off_out                <= 1'b1; // [RULE_13]
      motion_accept_out              <= 1'b0;
      immediate_stop_out             <= 1'b0;
    end else begin
      if (sense_s2.overcurrent && cfg[MDFS_CFG_OCSD_BIT]) begin
        oc_off <= 1'b1; // [RULE_03]
      end else if (read_and_clear_status_cmd) begin
        oc_off <= 1'b0; // [RULE_04]
      end
      bridges_off_out <= st.bridges_high_impedance_flag | oc_off |
                         thermal_sd_active; // [RULE_04]
      motion_accept_out  <= motion_ok; // [RULE_07]
      immediate_stop_out <= sw_fall & ~cfg[MDFS_CFG_SWSEL_BIT]; // [RULE_20]
    end
  end

  //--------------------------------------------------------------------
  // Converter sampling and alarm pin
  //--------------------------------------------------------------------
  logic         boot_alarm;
  logic [7:0]   alarm_src;

  // Converter value crosses two flip-flops, in step with the marker;
  // one sample per PWM period is taken on the marker's rising edge.
  always_ff @(posedge sys_clk_in or posedge rst) begin
    if (rst) begin
      adc_s1     <= '0;
      adc_s2     <= '0;
      adc_result <= '0;
    end else begin
      adc_s1 <= adc_sample_in;
      adc_s2 <= adc_s1;
      if (pwm_s2 && !pwm_d) begin
        adc_result <= adc_s2; // [RULE_21]
      end
    end
  end

  assign alarm_src = {2'b00, st.switch_event_flag,
                      ~st.undervoltage_flag, ~st.thermal_shutdown_flag,
                      ~st.thermal_warning_flag, ~st.overcurrent_flag,
                      boot_alarm};

  // Open-drain alarm: enable high pulls the pin low.
  always_ff @(posedge sys_clk_in or posedge rst) begin
    if (rst) begin
      boot_alarm     <= 1'b1;
      alarm_n_out    <= 1'b0;
      alarm_n_oe_out <= 1'b0;
    end else begin
      if (read_and_clear_status_cmd) begin
        boot_alarm <= 1'b0;
      end
      alarm_n_out    <= 1'b0;
      alarm_n_oe_out <= |(alarm_src & alarm_en); // [RULE_22]
    end
  end

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  default clocking mdfs_cb @(posedge sys_clk_in); endclocking
  default disable iff (rst);

  sequence oc_seen_s;
    sense_s2.overcurrent;
  endsequence

  oc_flag_low_a: assert property ( // [RULE_01]
    oc_seen_s |=> !st.overcurrent_flag)
    else $error("overcurrent flag not low");
  oc_hold_a: assert property ( // [RULE_01]
    (!st.overcurrent_flag && !read_and_clear_status_cmd) |=>
      !st.overcurrent_flag)
    else $error("overcurrent flag released early");
  oc_off_a: assert property ( // [RULE_04]
    (oc_off && !read_and_clear_status_cmd) |=> ##1 bridges_off_out)
    else $error("bridges on during overcurrent lockout");
  uv_block_a: assert property ( // [RULE_07]
    uv_present |=> !motion_accept_out)
    else $error("motion accepted in undervoltage");
  tsd_hiz_a: assert property ( // [RULE_10]
    sense_s2.temp_over_shutdown |=>
      (st.bridges_high_impedance_flag && !st.thermal_shutdown_flag))
    else $error("thermal shutdown not applied");
  tsd_end_a: assert property ( // [RULE_11]
    (thermal_sd_active && sense_s2.temp_over_warning) |=>
      thermal_sd_active)
    else $error("thermal shutdown ended too soon");
  sw_event_a: assert property ( // [RULE_19] [RULE_20]
    sw_fall |=> (st.switch_event_flag &&
                 immediate_stop_out == !$past(cfg[MDFS_CFG_SWSEL_BIT])))
    else $error("switch event mishandled");
  sw_level_a: assert property ( // [RULE_18]
    ##1 st.switch_level_flag == $past(sense_s2.switch_closed))
    else $error("switch level stale");

endmodule

/* File: rtl/mdfs_pkg.sv */
// Purpose: Constants and types for the motor driver fault and status block.
// Assumes: 20 MHz system clock; AXI4-Lite register access, 32-bit data.
// Notes:   Register offsets are byte addresses of aligned words.
//
// What this block and its host should do
// RULE_01: Overcurrent flag goes low on overcurrent, held until clear and status read.
// RULE_02: Overcurrent threshold selects one of sixteen 375 mA steps up to 6 A; the code only stores the value and reads it back.
// RULE_03: Shutdown enable bit decides bridge turn-off; flag is always raised.
// RULE_04: Outputs stay off after overcurrent until the flag is released.
// RULE_05: Host should keep overcurrent shutdown enabled.
// RULE_06: Undervoltage flag low below off level; released by read after on level.
// RULE_07: Motion commands are refused while undervoltage is present.
// RULE_08: Every logic reset drives the undervoltage flag low.
// RULE_09: Thermal warning flag low until cool and a status read arrives.
// RULE_10: Thermal shutdown drives flag low, forces bridges off, sets high-Z flag.
// RULE_11: Thermal shutdown ends only below the warning temperature.
// RULE_12: After thermal shutdown bridges stay off until an accepted motion command.
// RULE_13: Standby pin low holds bridges off and resets all logic.
// RULE_14: Host holds standby pin low for the minimum standby time.
// RULE_15: Host waits logic and charge pump wake-up delays before commands.
// RULE_16: Leaving standby, bridges stay off until a motion command executes.
// RULE_17: Host should put bridges in high impedance before resetting.
// RULE_18: Switch level flag is 1 when closed, refreshed every cycle.
// RULE_19: Falling switch edge sets the event flag until a status read.
// RULE_20: Switch stop select 0 stops immediately on turn-on; 1 only reports.
// RULE_21: Converter result is sampled once per PWM period into a register.
// RULE_22: Alarm pin pulled low by enabled alarms; masked ones still act.
// RULE_23: A one-cycle status read strobe releases flags whose cause ended.
package mdfs_pkg;

  // Register byte offsets.
  localparam logic [7:0] MDFS_CFG_OFF    = 8'h00;
  localparam logic [7:0] MDFS_STATUS_OFF = 8'h04;
  localparam logic [7:0] MDFS_ADC_OFF    = 8'h08;
  localparam logic [7:0] MDFS_ALARM_OFF  = 8'h0C;
  localparam logic [7:0] MDFS_CMD_OFF    = 8'h10;
  localparam logic [7:0] MDFS_OCTH_OFF   = 8'h14;

  // Configuration field positions and reset values.
  localparam int          MDFS_CFG_SWSEL_BIT = 0;
  localparam int          MDFS_CFG_OCSD_BIT  = 1;
  localparam logic [1:0]  MDFS_CFG_RST       = 2'h2;
  localparam logic [7:0]  MDFS_ALARM_RST     = 8'hFF;
  localparam logic [3:0]  MDFS_OCTH_RST      = 4'h8;

  // Threshold step and count, in milliamps.
  localparam int MDFS_OCTH_STEP_MA = 375;
  localparam int MDFS_OCTH_LEVELS  = 16;

  // Command register bits (write one to issue).
  localparam int MDFS_CMD_READ_BIT   = 0;
  localparam int MDFS_CMD_MOTION_BIT = 1;

  // Alarm enable bit positions.
  localparam int MDFS_AL_RESET = 0;
  localparam int MDFS_AL_OC    = 1;
  localparam int MDFS_AL_TWRN  = 2;
  localparam int MDFS_AL_TSD   = 3;
  localparam int MDFS_AL_UV    = 4;
  localparam int MDFS_AL_SW    = 5;

  // AXI responses.
  localparam logic [1:0] MDFS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MDFS_RESP_SLVERR = 2'h2;

  // Analog comparator and sensor inputs, all asynchronous.
  typedef struct packed {
    logic overcurrent;
    logic supply_below_off;
    logic supply_above_on;
    logic temp_over_warning;
    logic temp_over_shutdown;
    logic switch_closed;
  } mdfs_sense_t;

  // Status flags; the protection flags are active low.
  typedef struct packed {
    logic switch_event_flag;
    logic switch_level_flag;
    logic thermal_shutdown_flag;
    logic thermal_warning_flag;
    logic undervoltage_flag;
    logic overcurrent_flag;
    logic bridges_high_impedance_flag;
  } mdfs_status_t;

endpackage

/* File: bench/mdfs_host_model.sv */
// Purpose: Host side of the standby pin for the fault and status block.
// Assumes: Sleep requests come from the bench as levels on its clock.
// Notes:   Stands in for the microcontroller that owns the standby pin.
`timescale 1ns/100ps

module mdfs_host_model #(
  parameter int STBY_MIN = 4,
  parameter int WAKE     = 4
) (
  input  wire logic clk_in,
  input  wire logic sleep_req_in,
  output logic      standby_reset_pin_n_out,
  output logic      awake_out
);
  // -------------------------------------------------------------------
  // Standby sequencing
  // -------------------------------------------------------------------
  // Holds the pin low long enough, then waits before allowing traffic.
  initial begin
    standby_reset_pin_n_out = 1'h1;
    awake_out = 1'h1;
    forever begin
      do @(posedge clk_in); while (!sleep_req_in);
      standby_reset_pin_n_out <= 1'h0;
      awake_out <= 1'h0;
      repeat (STBY_MIN) @(posedge clk_in);
      while (sleep_req_in) @(posedge clk_in);
      standby_reset_pin_n_out <= 1'h1;
      repeat (WAKE) @(posedge clk_in);
      awake_out <= 1'h1;
    end
  end
endmodule

/* File: bench/mdfs_top_tb_top.sv */
// Purpose: Self-checking bench for the fault and status block.
// Assumes: Register access over AXI4-Lite, inputs driven on rising edges.
// Notes:   Sense changes are given six cycles to pass the synchronisers.
`timescale 1ns/100ps

module motor_driver_fault_status_tb_top;
  import mdfs_pkg::*;
  logic         sys_clk_in;
  logic         sys_rst_in;
  logic         sleep_req;
  logic         pwm;
  mdfs_sense_t  sense;
  logic [4:0]   adc;
  logic [31:0]  awaddr;
  logic [31:0]  wdata;
  logic [31:0]  araddr;
  logic [31:0]  rdata;
  logic [31:0]  d;
  logic [3:0]   wstrb;
  logic [1:0]   bresp;
  logic [1:0]   rresp;
  logic [1:0]   r;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready;
  logic         bridges_off, stop, accept, alarm_n, alarm_oe;
  logic         stby_n, awake;
  int           n_errors, checked, cycles, n_acc, n_stop, n0;

  mdfs_host_model HOST (.clk_in(sys_clk_in), .sleep_req_in(sleep_req),
    .standby_reset_pin_n_out(stby_n), .awake_out(awake));

  mdfs_top #(.ADC_W(5)) DUT (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .standby_reset_pin_n_in(stby_n), .sense_in(sense),
    .pwm_period_in(pwm), .adc_sample_in(adc),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bridges_off_out(bridges_off),
    .immediate_stop_out(stop), .motion_accept_out(accept),
    .alarm_n_out(alarm_n), .alarm_n_oe_out(alarm_oe));

  // -------------------------------------------------------------------
  // Clock, watchdog and pulse counters
  // -------------------------------------------------------------------
  // The clock toggles every half period of 25 ns.
  always #25 sys_clk_in = ~sys_clk_in;

  // Counts pulses and cuts a hang short well past the expected run.
  always @(posedge sys_clk_in) begin
    cycles++;
    if (accept === 1'h1) n_acc++;
    if (stop === 1'h1) n_stop++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  // Compares and counts; reports a difference at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // Write; each channel released at the edge it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_in);
    awaddr <= 32'(a);
    awvalid <= 1'h1;
    wdata <= v;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge sys_clk_in);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready));
    bready <= 1'h0;
    chk(32'(bresp), 32'(MDFS_RESP_OKAY));
  endtask

  // Read; data and response taken at the edge rvalid is seen.
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    @(posedge sys_clk_in);
    araddr <= 32'(a);
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge sys_clk_in);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready));
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask

  // Reading status also acts as the status-read command.
  task automatic st(input logic [6:0] e);
    rd(MDFS_STATUS_OFF, d, r);
    chk(d, {25'h0, e});
  endtask

  task automatic test_done();
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    sys_clk_in = 1'h0;
    sys_rst_in = 1'h1;
    {sleep_req, pwm, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    sense = '0;
    sense.supply_above_on = 1'h1;
    {adc, awaddr, wdata, araddr} = '0;
    wstrb = 4'hF;
    {n_errors, checked, cycles, n_acc, n_stop} = '0;
    tick(6);
    sys_rst_in <= 1'h0;
    tick(4);
    rd(MDFS_CFG_OFF, d, r);
    chk(d, 32'(MDFS_CFG_RST));
    chk(32'(alarm_oe), 32'h1);
    chk(32'(alarm_n), 32'h0);
    wr(MDFS_CFG_OFF, 32'h3);
    chk(32'(bridges_off), 32'h1);
    sleep_req <= 1'h1;
    tick(5);
    chk(32'(bridges_off), 32'h1);
    sleep_req <= 1'h0;
    while (!awake) tick(1);
    rd(MDFS_CFG_OFF, d, r);
    chk(d, 32'(MDFS_CFG_RST));
    chk(32'(alarm_oe), 32'h1);
    st(7'h1B);
    st(7'h1F);
    rd(8'h20, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(MDFS_RESP_SLVERR));
    for (int i = 0; i < MDFS_OCTH_LEVELS; i++) begin
      wr(MDFS_OCTH_OFF, 32'(i));
      rd(MDFS_OCTH_OFF, d, r);
      chk(d, 32'(i));
    end
    chk(32'(bridges_off), 32'h1);
    wr(MDFS_CMD_OFF, 32'h2);
    tick(3);
    chk(32'(bridges_off), 32'h0);
    // Overcurrent with shutdown enabled, then disabled.
    sense.overcurrent <= 1'h1;
    tick(6);
    chk(32'(bridges_off), 32'h1);
    st(7'h1D);
    sense.overcurrent <= 1'h0;
    tick(6);
    n0 = n_acc;
    wr(MDFS_CMD_OFF, 32'h2);
    tick(3);
    chk(32'(bridges_off), 32'h1);
    chk(32'(n_acc - n0), 32'h0);
    st(7'h1D);
    st(7'h1F);
    wr(MDFS_CMD_OFF, 32'h2);
    tick(3);
    chk(32'(bridges_off), 32'h0);
    wr(MDFS_CFG_OFF, 32'h0);
    sense.overcurrent <= 1'h1;
    tick(6);
    chk(32'(bridges_off), 32'h0);
    sense.overcurrent <= 1'h0;
    tick(6);
    st(7'h1C);
    st(7'h1E);
    wr(MDFS_CFG_OFF, 32'h2);
    // Undervoltage between the two thresholds.
    sense.supply_below_off <= 1'h1;
    sense.supply_above_on <= 1'h0;
    tick(6);
    n0 = n_acc;
    wr(MDFS_CMD_OFF, 32'h2);
    tick(3);
    chk(32'(n_acc - n0), 32'h0);
    sense.supply_below_off <= 1'h0;
    tick(6);
    st(7'h1A);
    sense.supply_above_on <= 1'h1;
    tick(6);
    st(7'h1A);
    st(7'h1E);
    // Switch with stop enabled, then as status only and masked.
    n0 = n_stop;
    sense.switch_closed <= 1'h1;
    tick(6);
    chk(32'(n_stop - n0), 32'h1);
    st(7'h7E);
    sense.switch_closed <= 1'h0;
    tick(6);
    st(7'h1E);
    st(7'h1E);
    wr(MDFS_CFG_OFF, 32'h3);
    wr(MDFS_ALARM_OFF, 32'h0);
    n0 = n_stop;
    sense.switch_closed <= 1'h1;
    tick(6);
    chk(32'(n_stop - n0), 32'h0);
    chk(32'(alarm_oe), 32'h0);
    st(7'h7E);
    sense.switch_closed <= 1'h0;
    tick(6);
    st(7'h1E);
    wr(MDFS_CFG_OFF, 32'h2);
    wr(MDFS_ALARM_OFF, 32'hFF);
    // Converter samples on two period markers.
    for (int i = 0; i < 2; i++) begin
      adc <= i ? 5'h0A : 5'h15;
      tick(2);
      pwm <= 1'h1;
      tick(6);
      pwm <= 1'h0;
      rd(MDFS_ADC_OFF, d, r);
      chk(d, 32'(adc));
    end
    // Thermal warning, shutdown, and exit through a motion command.
    sense.temp_over_warning <= 1'h1;
    tick(6);
    st(7'h16);
    sense.temp_over_shutdown <= 1'h1;
    tick(6);
    chk(32'(bridges_off), 32'h1);
    st(7'h07);
    sense.temp_over_shutdown <= 1'h0;
    tick(6);
    st(7'h07);
    sense.temp_over_warning <= 1'h0;
    tick(6);
    st(7'h17);
    st(7'h1F);
    chk(32'(bridges_off), 32'h1);
    n0 = n_acc;
    wr(MDFS_CMD_OFF, 32'h2);
    tick(3);
    chk(32'(bridges_off), 32'h0);
    chk(32'(n_acc - n0), 32'h1);
    test_done();
  end
endmodule
